// file: core/ccbf_defines.vh
`ifndef CCBF_DEFINES_VH
`define CCBF_DEFINES_VH

// register byte offsets
`define CCBF_OFS_CMD        8'h00
`define CCBF_OFS_STATUS     8'h04
`define CCBF_OFS_BRANCH     8'h08
`define CCBF_OFS_FLAGS      8'h0C
`define CCBF_OFS_IADDR      8'h10
`define CCBF_OFS_UADDR      8'h14

// command register fields
`define CCBF_CMD_ARITH      0
`define CCBF_CMD_BRANCH     1
`define CCBF_CMD_ZERO       4
`define CCBF_CMD_NEG        5
`define CCBF_CMD_OVF        6
`define CCBF_CMD_MASK_LO    8
`define CCBF_CMD_MASK_HI    11

// flag register fields
`define CCBF_FLG_MATCH      0
`define CCBF_FLG_REGZERO    1
`define CCBF_FLG_ERROR      2
`define CCBF_FLG_PROGINT    3
`define CCBF_FLG_W          4

// condition codes, upper nibble of the status byte
`define CCBF_CC_ZERO        4'h8
`define CCBF_CC_NEG         4'h4
`define CCBF_CC_POS         4'h2
`define CCBF_CC_OVF         4'h1

// fixed-point overflow mask bit in the status byte
`define CCBF_OVF_MASK       8'h08

// microaddresses
`define CCBF_UA_FETCH       16'h0100
`define CCBF_UA_INTID       16'h0101

// reset values
`define CCBF_RST_STATUS     8'h00
`define CCBF_RST_BRANCH     32'h0000_0000
`define CCBF_RST_IADDR      16'h0000
`define CCBF_RST_IA_BYTE    8'h00

// sequencer states
`define CCBF_ST_IDLE        4'h0
`define CCBF_ST_MERGE       4'h1
`define CCBF_ST_MASK        4'h2
`define CCBF_ST_FINISH      4'h3
`define CCBF_ST_BR_TEST     4'h4
`define CCBF_ST_BR_DECIDE   4'h5
`define CCBF_ST_BR_UNAVAIL  4'h6
`define CCBF_ST_BR_BOUND    4'h7
`define CCBF_ST_BR_LOAD     4'h8

`endif

// file: core/status_byte_merge.v
`timescale 1ns/100ps
`default_nettype none
`include "ccbf_defines.vh"

module status_byte_merge
(
    input  wire [7:0] status_byte,   // current status byte
    input  wire [3:0] cond_code,     // new condition code
    output wire [7:0] merged_byte,   // code high, old mask low
    output wire [7:0] ovf_zbus       // overflow mask test result
);

    assign merged_byte = {cond_code, status_byte[3:0]};
    assign ovf_zbus    = {4'h0, status_byte[3:0]} & `CCBF_OVF_MASK;

endmodule

`default_nettype wire

// file: core/branch_check.v
`timescale 1ns/100ps
`default_nettype none

module branch_check
(
    input  wire [31:0] branch_reg,   // branch address register
    input  wire [3:0]  cond_code,    // current condition code
    input  wire [3:0]  branch_mask,  // instruction mask field
    output wire        cc_match,     // code selected by mask
    output wire        reg_zero,     // branch register all zero
    output wire        unavail,      // second byte nonzero
    output wire        misaligned    // not on halfword boundary
);

    assign cc_match   = |(cond_code & branch_mask);
    assign reg_zero   = ~|branch_reg;
    assign unavail    = |branch_reg[23:16];
    assign misaligned = branch_reg[0];

endmodule

`default_nettype wire

// file: core/cond_code_and_branch_finish.v
// Overview of operation
// - status byte: condition code in upper nibble, program mask in lower
// - positive result without overflow writes code 0010
// - overflow writes code 0001
// - overflow tests mask bit 00001000; zero means no program interrupt
// - status update replaces only the code; mask bits kept
// - finish goes to 0101 if interrupt pending, else 0100
// - zero result bus sets low bit of next microaddress
// - branch taken only if match flag one and register-zero flag zero
// - nonzero second byte of branch register sets error flag
// - boundary test sets error if misaligned, clears it if aligned
// - taken branch loads low byte to low, third byte to high address
// - flags hold until an explicit clear, error also cleared by an aligned boundary test; zero test never clears them
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ccbf_defines.vh"

module cond_code_and_branch_finish
(
    input  wire        clk,                // 125 MHz clock
    input  wire        reset_n,            // async reset, active low
    input  wire [7:0]  addr,               // register byte address
    input  wire [31:0] wdata,              // write data
    input  wire        wr,                 // write strobe
    input  wire        rd,                 // read strobe
    input  wire        interrupt_pending,  // interrupt waiting, same clock
    output reg  [31:0] rdata_q,            // read data, cycle after rd
    output reg  [15:0] next_uaddr_q,       // next microaddress
    output reg         busy_q,             // sequence running
    output reg         done_q,             // sequence finished pulse
    output reg         prog_int_q          // program interrupt pulse
);

    ////////////////////////////////////////////////////////////////////////
    // state and registers

    reg  [3:0]              state_q;
    reg  [7:0]              status_q;
    reg  [31:0]             branch_q;
    reg  [7:0]              ia_low_q;
    reg  [7:0]              ia_high_q;
    reg  [`CCBF_FLG_W-1:0]  flags_q;
    reg  [3:0]              cc_sel_q;
    reg  [3:0]              mask_q;
    reg                     ovf_q;

    reg  [`CCBF_FLG_W-1:0]  hw_set;
    reg  [`CCBF_FLG_W-1:0]  hw_clr;
    wire [`CCBF_FLG_W-1:0]  sw_clr;

    wire [7:0]              merged_byte;
    wire [7:0]              ovf_zbus;
    wire                    cc_match;
    wire                    reg_zero;
    wire                    unavail;
    wire                    misaligned;

    wire                    wr_cmd;
    wire                    start_arith;
    wire                    start_branch;
    wire                    idle;
    wire                    wr_status;
    wire                    wr_branch;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    status_byte_merge status_byte_merge_inst
    (
        .status_byte (status_q),
        .cond_code   (cc_sel_q),
        .merged_byte (merged_byte),
        .ovf_zbus    (ovf_zbus)
    );

    branch_check branch_check_inst
    (
        .branch_reg  (branch_q),
        .cond_code   (status_q[7:4]),
        .branch_mask (mask_q),
        .cc_match    (cc_match),
        .reg_zero    (reg_zero),
        .unavail     (unavail),
        .misaligned  (misaligned)
    );

    ////////////////////////////////////////////////////////////////////////
    // command decode

    assign idle         = (state_q == `CCBF_ST_IDLE);
    assign wr_cmd       = wr && (addr == `CCBF_OFS_CMD) && idle;
    assign start_arith  = wr_cmd && wdata[`CCBF_CMD_ARITH];
    assign start_branch = wr_cmd && !wdata[`CCBF_CMD_ARITH] && wdata[`CCBF_CMD_BRANCH];
    assign wr_status    = wr && idle && (addr == `CCBF_OFS_STATUS);
    assign wr_branch    = wr && idle && (addr == `CCBF_OFS_BRANCH);
    assign sw_clr       = (wr && (addr == `CCBF_OFS_FLAGS)) ? wdata[`CCBF_FLG_W-1:0]
                                                            : {`CCBF_FLG_W{1'b0}};

    ////////////////////////////////////////////////////////////////////////
    // flag set and clear microorders

    always @*
    begin
        hw_set = {`CCBF_FLG_W{1'b0}};
        hw_clr = {`CCBF_FLG_W{1'b0}};
        case (state_q)
            `CCBF_ST_BR_TEST:
            begin
                hw_set[`CCBF_FLG_MATCH]   = cc_match;
                hw_set[`CCBF_FLG_REGZERO] = reg_zero;
            end
            `CCBF_ST_BR_UNAVAIL:
            begin
                hw_set[`CCBF_FLG_ERROR] = unavail;
            end
            `CCBF_ST_BR_BOUND:
            begin
                hw_set[`CCBF_FLG_ERROR] = misaligned;
                hw_clr[`CCBF_FLG_ERROR] = !misaligned;
            end
            `CCBF_ST_MASK:
            begin
                hw_set[`CCBF_FLG_PROGINT] = (ovf_zbus != 8'h00);
            end
            default:
            begin
                hw_set = {`CCBF_FLG_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flags_q <= {`CCBF_FLG_W{1'b0}};
        else
            flags_q <= (flags_q & ~sw_clr & ~hw_clr) | hw_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q      <= `CCBF_ST_IDLE;
            status_q     <= `CCBF_RST_STATUS;
            branch_q     <= `CCBF_RST_BRANCH;
            ia_low_q     <= `CCBF_RST_IA_BYTE;
            ia_high_q    <= `CCBF_RST_IA_BYTE;
            cc_sel_q     <= 4'h0;
            mask_q       <= 4'h0;
            ovf_q        <= 1'b0;
            next_uaddr_q <= `CCBF_UA_FETCH;
            busy_q       <= 1'b0;
            done_q       <= 1'b0;
            prog_int_q   <= 1'b0;
        end
        else
        begin
            done_q     <= 1'b0;
            prog_int_q <= 1'b0;
            // status and branch writes ignored while busy; flag clears still act
            if (wr_status)
                status_q <= wdata[7:0];
            if (wr_branch)
                branch_q <= wdata;
            case (state_q)
                `CCBF_ST_IDLE:
                begin
                    if (start_arith)
                    begin
                        ovf_q  <= wdata[`CCBF_CMD_OVF];
                        busy_q <= 1'b1;
                        state_q <= `CCBF_ST_MERGE;
                        if (wdata[`CCBF_CMD_OVF])
                            cc_sel_q <= `CCBF_CC_OVF;
                        else if (wdata[`CCBF_CMD_ZERO])
                            cc_sel_q <= `CCBF_CC_ZERO;
                        else if (wdata[`CCBF_CMD_NEG])
                            cc_sel_q <= `CCBF_CC_NEG;
                        else
                            cc_sel_q <= `CCBF_CC_POS;
                    end
                    else if (start_branch)
                    begin
                        mask_q  <= wdata[`CCBF_CMD_MASK_HI:`CCBF_CMD_MASK_LO];
                        busy_q  <= 1'b1;
                        state_q <= `CCBF_ST_BR_TEST;
                    end
                end
                `CCBF_ST_MERGE:
                begin
                    status_q <= merged_byte;
                    if (ovf_q)
                        state_q <= `CCBF_ST_MASK;
                    else
                        state_q <= `CCBF_ST_FINISH;
                end
                `CCBF_ST_MASK:
                begin
                    next_uaddr_q[0] <= (ovf_zbus == 8'h00);
                    prog_int_q <= (ovf_zbus != 8'h00);
                    state_q    <= `CCBF_ST_FINISH;
                end
                `CCBF_ST_BR_TEST:
                begin
                    state_q <= `CCBF_ST_BR_DECIDE;
                end
                `CCBF_ST_BR_DECIDE:
                begin
                    if (flags_q[`CCBF_FLG_MATCH] && !flags_q[`CCBF_FLG_REGZERO])
                        state_q <= `CCBF_ST_BR_UNAVAIL;
                    else
                        state_q <= `CCBF_ST_FINISH;
                end
                `CCBF_ST_BR_UNAVAIL:
                begin
                    if (unavail)
                        state_q <= `CCBF_ST_FINISH;
                    else
                        state_q <= `CCBF_ST_BR_BOUND;
                end
                `CCBF_ST_BR_BOUND:
                begin
                    if (misaligned)
                        state_q <= `CCBF_ST_FINISH;
                    else
                        state_q <= `CCBF_ST_BR_LOAD;
                end
                `CCBF_ST_BR_LOAD:
                begin
                    // addresses untouched on error
                    // load address pair
                    ia_low_q  <= branch_q[7:0];
                    ia_high_q <= branch_q[15:8];
                    state_q   <= `CCBF_ST_FINISH;
                end
                `CCBF_ST_FINISH:
                begin
                    if (interrupt_pending)
                        next_uaddr_q <= `CCBF_UA_INTID;
                    else
                        next_uaddr_q <= `CCBF_UA_FETCH;
                    done_q  <= 1'b1;
                    busy_q  <= 1'b0;
                    state_q <= `CCBF_ST_IDLE;
                end
                default:
                begin
                    busy_q  <= 1'b0;
                    state_q <= `CCBF_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 32'h0000_0000;
        // data stands one cycle, else zero
        else if (rd)
        begin
            if (addr == `CCBF_OFS_CMD)
                rdata_q <= {27'h000_0000, busy_q, state_q};
            else if (addr == `CCBF_OFS_STATUS)
                rdata_q <= {24'h00_0000, status_q};
            else if (addr == `CCBF_OFS_BRANCH)
                rdata_q <= branch_q;
            else if (addr == `CCBF_OFS_FLAGS)
                rdata_q <= {28'h000_0000, flags_q};
            else if (addr == `CCBF_OFS_IADDR)
                rdata_q <= {16'h0000, ia_high_q, ia_low_q};
            else if (addr == `CCBF_OFS_UADDR)
                rdata_q <= {16'h0000, next_uaddr_q};
            else
                rdata_q <= 32'h0000_0000;
        end
        else
            rdata_q <= 32'h0000_0000;
    end

endmodule

`default_nettype wire

// file: verif/cond_code_and_branch_finish_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccbf_defines.vh"
module cond_code_and_branch_finish_properties
(
    input wire logic        clk,               // clock
    input wire logic        reset_n,           // reset, active low
    input wire logic [7:0]  addr,              // register address
    input wire logic [31:0] wdata,             // write data
    input wire logic        wr,                // write strobe
    input wire logic        rd,                // read strobe
    input wire logic        interrupt_pending, // interrupt waiting
    input wire logic [31:0] rdata_q,           // read data
    input wire logic [15:0] next_uaddr_q,      // next microaddress
    input wire logic        busy_q,            // sequence running
    input wire logic        done_q,            // sequence end
    input wire logic        prog_int_q         // program interrupt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // command accepted while idle
    wire cmd_wr = wr && addr == `CCBF_OFS_CMD && !busy_q;
    ////////////////////////////////////////////////////////////////
    property p_start;
        cmd_wr && wdata[1:0] != 2'b00 |=> busy_q;
    endproperty
    a_start: assert property (p_start) else $error("command did not start");
    property p_arith_plain;
        cmd_wr && wdata[0] && !wdata[6] |-> ##1 !done_q ##1 !done_q ##1 done_q;
    endproperty
    a_arith_plain: assert property (p_arith_plain) else $error("plain finish timing");
    property p_arith_ovf;
        cmd_wr && wdata[0] && wdata[6] |-> ##1 !done_q[*3] ##1 done_q;
    endproperty
    a_arith_ovf: assert property (p_arith_ovf) else $error("overflow finish timing");
    property p_prog_int;
        prog_int_q |-> busy_q && !next_uaddr_q[0] ##1 done_q;
    endproperty
    a_prog_int: assert property (p_prog_int) else $error("program interrupt misplaced");
    property p_zero_bit;
        cmd_wr && wdata[0] && wdata[6] |-> ##3 next_uaddr_q[0] == !prog_int_q;
    endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("zero test bit wrong");
    property p_finish_target;
        done_q |-> next_uaddr_q == ($past(interrupt_pending) ? `CCBF_UA_INTID : `CCBF_UA_FETCH);
    endproperty
    a_finish_target: assert property (p_finish_target) else $error("wrong finish target");
    property p_done_pulse;
        done_q |-> !busy_q ##1 !done_q;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    property p_branch_time;
        cmd_wr && wdata[1] && !wdata[0] |-> ##1 !done_q[*3] ##[1:4] done_q;
    endproperty
    a_branch_time: assert property (p_branch_time) else $error("branch finish timing");
    property p_uaddr_hold;
        $changed(next_uaddr_q) |-> $past(busy_q);
    endproperty
    a_uaddr_hold: assert property (p_uaddr_hold) else $error("microaddress moved while idle");
endmodule
`default_nettype wire

// file: verif/cond_code_and_branch_finish_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccbf_defines.vh"
module cond_code_and_branch_finish_tb;
    logic        clk;
    logic        reset_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        interrupt_pending;
    wire  [31:0] rdata_q;
    wire  [15:0] next_uaddr_q;
    wire         busy_q;
    wire         done_q;
    wire         prog_int_q;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic        int_seen;
    cond_code_and_branch_finish cond_code_and_branch_finish_inst
    (
        .clk, .reset_n, .addr, .wdata, .wr, .rd, .interrupt_pending,
        .rdata_q, .next_uaddr_q, .busy_q, .done_q, .prog_int_q
    );
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata_q;
    endtask
    // start a sequence, wait bounded for its end
    task automatic run_cmd(input logic [31:0] c);
        int n;
        wr_reg(`CCBF_OFS_CMD, c);
        int_seen = 1'b0;
        n = 0;
        while (done_q !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            int_seen = int_seen | (prog_int_q === 1'b1);
            n++;
        end
        check({31'h0000_0000, done_q}, 32'h0000_0001);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic reset_values();
        logic [31:0] d;
        check({16'h0000, next_uaddr_q}, 32'h0000_0100);
        rd_reg(`CCBF_OFS_STATUS, d);
        check(d, 32'h0000_0000);
        rd_reg(8'h40, d);
        check(d, 32'h0000_0000);
    endtask
    task automatic arith_one(input logic [7:0] s, input logic [7:0] c, input logic ip,
                             input logic [7:0] es, input logic [15:0] eu, input logic ep);
        logic [31:0] d;
        wr_reg(`CCBF_OFS_STATUS, {24'h00_0000, s});
        interrupt_pending <= ip;
        run_cmd({24'h00_0000, c});
        check({31'h0000_0000, int_seen}, {31'h0000_0000, ep});
        check({16'h0000, next_uaddr_q}, {16'h0000, eu});
        rd_reg(`CCBF_OFS_STATUS, d);
        check(d, {24'h00_0000, es});
    endtask
    task automatic branch_one(input logic [31:0] b, input logic [3:0] m, input logic clr,
                              input logic [15:0] ei, input logic [2:0] ef);
        logic [31:0] d;
        if (clr)
            wr_reg(`CCBF_OFS_FLAGS, 32'h0000_000F);
        wr_reg(`CCBF_OFS_BRANCH, b);
        run_cmd({20'h0_0000, m, 8'h02});
        check({16'h0000, next_uaddr_q}, {16'h0000, `CCBF_UA_FETCH});
        rd_reg(`CCBF_OFS_IADDR, d);
        check(d & 32'h0000_FFFF, {16'h0000, ei});
        rd_reg(`CCBF_OFS_FLAGS, d);
        check(d & 32'h0000_0007, {29'h0000_0000, ef});
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        reset_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        interrupt_pending = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        reset_values();
        arith_one(8'h0A, 8'h01, 1'b0, 8'h2A, `CCBF_UA_FETCH, 1'b0);
        arith_one(8'h07, 8'h41, 1'b1, 8'h17, `CCBF_UA_INTID, 1'b0);
        arith_one(8'h0F, 8'h41, 1'b0, 8'h1F, `CCBF_UA_FETCH, 1'b1);
        arith_one(8'h05, 8'h11, 1'b1, 8'h85, `CCBF_UA_INTID, 1'b0);
        arith_one(8'hF3, 8'h21, 1'b0, 8'h43, `CCBF_UA_FETCH, 1'b0);
        arith_one(8'h08, 8'h71, 1'b1, 8'h18, `CCBF_UA_INTID, 1'b1);
        arith_one(8'h00, 8'h03, 1'b0, 8'h20, `CCBF_UA_FETCH, 1'b0);
        wr_reg(`CCBF_OFS_STATUS, 32'h0000_002F);
        interrupt_pending <= 1'b0;
        branch_one(32'h0000_1234, 4'h2, 1'b1, 16'h1234, 3'b001);
        branch_one(32'h0000_5678, 4'h4, 1'b1, 16'h1234, 3'b000);
        branch_one(32'h0012_0010, 4'h2, 1'b1, 16'h1234, 3'b101);
        branch_one(32'h0000_0011, 4'h2, 1'b1, 16'h1234, 3'b101);
        branch_one(32'h0000_0020, 4'h2, 1'b0, 16'h0020, 3'b001);
        branch_one(32'h0000_0000, 4'h2, 1'b1, 16'h0020, 3'b011);
        branch_one(32'h0000_3456, 4'h2, 1'b0, 16'h0020, 3'b011);
        give_verdict();
    end
endmodule
bind cond_code_and_branch_finish cond_code_and_branch_finish_properties cond_code_and_branch_finish_properties_inst
(
    .clk, .reset_n, .addr, .wdata, .wr, .rd, .interrupt_pending,
    .rdata_q, .next_uaddr_q, .busy_q, .done_q, .prog_int_q
);
`default_nettype wire
